// *** bench/i2c_master_model.sv ***
// Bus master model: drives the serial clock, pulls or releases data
`timescale 1ns/1ps
module i2c_master_model (
   output logic scl,
   output logic sda_rel,
   input wire logic sda_wire
);
   // Idle bus: clock stands high, data released to the pull-up
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end

   // start framing
   // Also a repeated start; long high phase lets the slow domain see it
   task automatic start_cond();
      #7 sda_rel = 1'b1;
      #8 scl = 1'b1;
      #40 sda_rel = 1'b0;
      // Odd hold keeps serial clock edges off the system clock edges
      #43 scl = 1'b0;
   endtask : start_cond

   task automatic stop_cond();
      #7 sda_rel = 1'b0;
      #8 scl = 1'b1;
      #15 sda_rel = 1'b1;
      #60;
   endtask : stop_cond

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic a0;
      logic a1;
      for (int i = 7; i >= 0; i--) begin
         #7 sda_rel = b[i];
         #8 scl = 1'b1;
         #15 scl = 1'b0;
      end
      // ack slot sampling
      // Only low at the rise and again just before the fall counts
      #7 sda_rel = 1'b1;
      #8 scl = 1'b1;
      a0 = sda_wire;
      #14 a1 = sda_wire;
      #1 scl = 1'b0;
      ack = (a0 === 1'b0) && (a1 === 1'b0);
   endtask : send_byte
endmodule : i2c_master_model

// *** bench/test_i2c_slave_register_write_port.sv ***
// Self-checking bench of the two-wire register write target
`timescale 1ns/1ps
module test_i2c_slave_register_write_port;
   import i2c_wr_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic [1:0] addr_opt = 2'h0;
   logic test_unlock = 1'b0;
   byte_t rd_addr = 8'h00;
   byte_t rd_data;
   byte_t wr_addr;
   byte_t wr_data;
   logic sda_o;
   logic sda_oe;
   logic wr_pulse;
   logic filt_hs;
   logic bus_free;
   logic scl;
   logic sda_rel;
   wire sda;
   int err_total = 0;
   int n_checks = 0;
   logic [31:0] lfsr = 32'h00010A08;
   byte_t tx[$];
   logic [15:0] seen_wr[$];
   logic [15:0] want_wr[$];

   always #5 clk_sys = ~clk_sys;
   // Open-drain wire: pulled up unless either side pulls low
   assign sda = sda_rel & (sda_oe ? sda_o : 1'b1);

   i2c_wr_target i2c_wr_target_inst (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
      .scl_link(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .addr_opt(addr_opt),
      .test_unlock(test_unlock), .rd_addr(rd_addr), .rd_data(rd_data), .wr_pulse(wr_pulse),
      .wr_addr(wr_addr), .wr_data(wr_data), .filt_hs(filt_hs), .bus_free(bus_free));
   i2c_master_model i2c_master_model_inst (.scl(scl), .sda_rel(sda_rel), .sda_wire(sda));

   // Commit monitor
   always @(posedge clk_sys) begin
      if (wr_pulse === 1'b1) begin
         seen_wr.push_back({wr_addr, wr_data});
      end
   end

   function automatic dev_addr_t main_addr(input logic [1:0] opt);
      dev_addr_t t[4] = '{7'h40, 7'h48, 7'h44, 7'h4C};
      return t[opt];
   endfunction : main_addr

   // only main or unlocked test address, write direction
   function automatic logic addr_acked(input byte_t f, input logic [1:0] o, input logic u);
      return f[0] == 1'b0 && (f[7:1] == main_addr(o) || (u && f[7:1] == 7'h49));
   endfunction : addr_acked

   // Eight register steps per byte, so successive bytes share no bits
   function automatic byte_t rnd8();
      repeat (8) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction : rnd8

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim

   task automatic fill(input byte_t first, input byte_t ptr, input int n);
      byte_t b;
      tx = '{first, ptr};
      repeat (n) begin
         b = rnd8();
         tx.push_back(b);
      end
   endtask : fill

   // Bounded wait for the free bus, then the gap before a new start
   task automatic wait_free();
      int n;
      n = 0;
      while (bus_free !== 1'b1 && n < 50) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 50) begin
         err_total++;
         $display("mismatch bus_free expected 1 seen %b", bus_free);
         end_sim();
      end
      repeat (4) @(posedge clk_sys);
   endtask : wait_free

   task automatic frame(input string name, input logic stop);
      logic hit;
      logic ack;
      hit = addr_acked(tx[0], addr_opt, test_unlock);
      i2c_master_model_inst.start_cond();
      foreach (tx[i]) begin
         i2c_master_model_inst.send_byte(tx[i], ack);
         check({name, " ack"}, {15'h0000, ack}, {15'h0000, hit});
         if (hit && i > 1) begin
            want_wr.push_back({8'(tx[1] + 8'(i - 2)), tx[i]});
         end
      end
      if (stop) begin
         i2c_master_model_inst.stop_cond();
         wait_free();
         check("filt_hs", {15'h0000, filt_hs}, 16'h0000);
         check("commits", 16'(seen_wr.size()), 16'(want_wr.size()));
         while (want_wr.size() > 0 && seen_wr.size() > 0) begin
            check("commit", seen_wr.pop_front(), want_wr.pop_front());
         end
         seen_wr.delete();
         want_wr.delete();
      end
      $display("test %s done", name);
   endtask : frame

   task automatic readback(input byte_t a, input byte_t e);
      rd_addr <= a;
      @(posedge clk_sys);
      @(posedge clk_sys);
      #1 check("store", {8'h00, rd_data}, {8'h00, e});
   endtask : readback

   task automatic hs_check(input logic e);
      repeat (6) @(posedge clk_sys);
      check("filt_hs", {15'h0000, filt_hs}, {15'h0000, e});
   endtask : hs_check

   initial begin
      byte_t p;
      byte_t refused[4] = '{8'h00, 8'hF8, 8'h92, 8'h99};
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      #1 check("filt_hs", {15'h0000, filt_hs}, 16'h0000);
      repeat (6) @(posedge clk_sys);
      // Each option, then the neighbour's address
      for (int o = 0; o < 4; o++) begin
         addr_opt <= 2'(o);
         @(posedge clk_sys);
         p = rnd8();
         fill({main_addr(2'(o)), 1'b0}, p, 1);
         frame("option", 1'b1);
         fill({main_addr(2'(o + 1)), 1'b0}, p, 1);
         frame("foreign", 1'b1);
      end
      // Refused: general call, device-ID, locked test, read
      foreach (refused[i]) begin
         p = rnd8();
         fill(refused[i], p, 2);
         frame("refused", 1'b1);
      end
      test_unlock <= 1'b1;
      @(posedge clk_sys);
      p = rnd8();
      fill(8'h92, p, 1);
      frame("test unlocked", 1'b1);
      test_unlock <= 1'b0;
      // Sequential writes, first one wrapping past the top pointer
      for (int k = 0; k < 4; k++) begin
         p = rnd8();
         if (k == 0) begin
            p = 8'hFE;
         end
         fill({main_addr(addr_opt), 1'b0}, p, 4);
         frame("sequential", 1'b1);
         readback(8'(p + 8'h03), tx[5]);
      end
      // Enable low freezes the read register, whatever the address does
      ce <= 1'b0;
      rd_addr <= 8'(p + 8'h02);
      repeat (3) @(posedge clk_sys);
      #1 check("frozen", {8'h00, rd_data}, {8'h00, tx[5]});
      @(posedge clk_sys);
      ce <= 1'b1;
      // Master code, repeated starts, then stop
      p = rnd8();
      tx = '{8'h08 | (p & 8'h07)};
      frame("hs code", 1'b0);
      hs_check(1'b1);
      fill({main_addr(addr_opt), 1'b0}, p, 2);
      frame("hs write", 1'b0);
      hs_check(1'b1);
      frame("hs stop", 1'b1);
      end_sim();
   end
endmodule : test_i2c_slave_register_write_port

// *** design/i2c_wr_consts.svh ***
// Constants of the two-wire register write target
`ifndef I2C_WR_CONSTS_SVH
`define I2C_WR_CONSTS_SVH

// ----------------------------------------
// Target addresses (7-bit)
// ----------------------------------------
`define ADDR_OPT0 7'h40
`define ADDR_OPT1 7'h48
`define ADDR_OPT2 7'h44
`define ADDR_OPT3 7'h4C
`define ADDR_TEST 7'h49
`define ADDR_GCALL 7'h00

// ----------------------------------------
// Framing and reset values
// ----------------------------------------
`define HS_CODE_TOP 5'h01
`define LAST_BIT 4'h7
`define ACK_SLOT 4'h8
`define PTR_RESET 8'h00
`define PTR_STEP 8'h01

`endif

// *** design/i2c_wr_pkg.sv ***
// Types shared by the two-wire register write target
package i2c_wr_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [6:0] dev_addr_t;
   typedef logic [3:0] bit_cnt_t;
   typedef enum logic [2:0] {st_idle, st_addr, st_ptr, st_data, st_ignore} link_state_t;
endpackage : i2c_wr_pkg

// *** design/i2c_wr_target.sv ***
// Two-wire slave write target: address match, pointer, sequential commit
// ----------------------------------------
// Behaviour
// R1: Receiver pulls data low through ninth clock
// R2: Not-acknowledge releases data for ninth clock
// R3: Every pointer value is acknowledged
// R4: Start then 7-bit address compared
// R5: Option selects main address 40/48/44/4C
// R6: Foreign addresses never acknowledged
// R7: Test address answered only when unlocked
// R8: Clock line never driven, no stretching
// R9: General call left unanswered and ignored
// R10: Device-ID query treated as foreign address
// R11: Works from static clock up to 3.4MHz
// R12: Power-up and stop select slow filters
// R13: Repeated start keeps filter selection
// R14: Write: address, direction 0, pointer, data
// R15: Data byte commits after its ack slot
// R16: Single data byte may be acknowledged
// R17: Further bytes acked, pointer advances
// R18: Master ends write by stop or restart
// R19: Master retries after missing acknowledge
// R20: Start and stop are data edges, clock high
// R21: Eight bits, most significant first, then ack
// R22: Master code gets nack, selects fast filters
// R23: Unmatched address ignored until next start
// R24: Address option static, sampled at compare
// ----------------------------------------
`timescale 1ns/1ps
`include "i2c_wr_consts.svh"
module i2c_wr_target #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   input wire logic scl_link,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic [1:0] addr_opt,
   input wire logic test_unlock,
   input wire i2c_wr_pkg::byte_t rd_addr,
   output i2c_wr_pkg::byte_t rd_data,
   output logic wr_pulse,
   output i2c_wr_pkg::byte_t wr_addr,
   output i2c_wr_pkg::byte_t wr_data,
   output logic filt_hs,
   output logic bus_free
);
   import i2c_wr_pkg::*;

   // ----------------------------------------
   // Link domain (serial clock)
   // ----------------------------------------
   link_state_t state;
   link_state_t next_state;
   bit_cnt_t cnt;
   bit_cnt_t next_cnt;
   byte_t shreg;
   byte_t next_shreg;
   logic next_oe;
   byte_t ptr;
   byte_t next_ptr;
   logic hs_tgl;
   logic next_hs_tgl;
   logic cm_tgl;
   logic next_cm_tgl;
   byte_t cm_addr;
   byte_t next_cm_addr;
   byte_t cm_data;
   byte_t next_cm_data;
   logic sda_hi;
   logic [1:0] opt_m;
   logic [1:0] opt_s;
   logic unlock_m;
   logic unlock_s;
   logic link_rst;
   byte_t rx_byte;
   logic start_now;
   logic hs_code;
   logic addr_hit;
   logic dir_wr;

   // Main address decode from the static option
   function automatic dev_addr_t main_addr(input logic [1:0] opt);
      case (opt)
         2'h0: main_addr = `ADDR_OPT0;
         2'h1: main_addr = `ADDR_OPT1;
         2'h2: main_addr = `ADDR_OPT2;
         default: main_addr = `ADDR_OPT3;
      endcase
   endfunction : main_addr

   // Data level at each rising clock edge; idle level after reset, so no false start
   always_ff @(posedge scl_link or posedge link_rst) begin
      if (link_rst) begin
         sda_hi <= 1'b1;
      end else begin
         sda_hi <= sda_i;
      end
   end

   // Static straps resynchronised onto the link clock
   always_ff @(negedge scl_link) begin
      opt_m <= addr_opt;
      opt_s <= opt_m;
      unlock_m <= test_unlock;
      unlock_s <= unlock_m;
   end

   // Byte decode; shift is MSB first
   always_comb begin
      // R21: MSB first
      rx_byte = {shreg[6:0], sda_hi};
      // R20: start edge
      start_now = sda_hi & ~sda_i;
      // R22: master code
      hs_code = (rx_byte[7:3] == `HS_CODE_TOP);
      // R4: address compare
      // R5: main address
      // R24: sampled here
      // R7: test gate
      // R10: no ID query
      addr_hit = (rx_byte[7:1] == main_addr(opt_s)) |
                 ((rx_byte[7:1] == `ADDR_TEST) & unlock_s);
      // R14: write bit
      dir_wr = ~rx_byte[0];
   end

   // Protocol engine, decisions on the falling clock edge
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_shreg = shreg;
      next_oe = 1'b0;
      next_ptr = ptr;
      next_hs_tgl = hs_tgl;
      next_cm_tgl = cm_tgl;
      next_cm_addr = cm_addr;
      next_cm_data = cm_data;
      if (start_now) begin
         // R18: restart ends write
         next_state = st_addr;
         next_cnt = '0;
      end else begin
         case (state)
            st_idle: begin
               // First fall after a start from a free bus
               if (!sda_i) begin
                  next_state = st_addr;
                  next_cnt = '0;
               end
            end
            st_ignore: begin
               // R23: quiet until start
               next_oe = 1'b0;
            end
            st_addr, st_ptr, st_data: begin
               if (cnt != `ACK_SLOT) begin
                  next_shreg = rx_byte;
                  next_cnt = cnt + 4'h1;
                  if (cnt == `LAST_BIT) begin
                     if (state == st_addr) begin
                        // R6: foreign nack
                        // R9: general call nack
                        // R2: release for nack
                        next_oe = addr_hit & dir_wr & ~hs_code;
                        // R22: hs entry
                        if (hs_code) begin
                           next_hs_tgl = ~hs_tgl;
                        end
                     end else begin
                        // R3: any pointer
                        // R16: data acked
                        // R1: pull low
                        next_oe = 1'b1;
                     end
                  end
               end else begin
                  next_cnt = '0;
                  case (state)
                     st_addr: begin
                        next_state = sda_oe ? st_ptr : st_ignore;
                     end
                     st_ptr: begin
                        next_ptr = shreg;
                        next_state = st_data;
                     end
                     default: begin
                        // R15: commit at release
                        next_cm_addr = ptr;
                        next_cm_data = shreg;
                        next_cm_tgl = ~cm_tgl;
                        // R17: pointer steps
                        next_ptr = ptr + `PTR_STEP;
                     end
                  endcase
               end
            end
            default: begin
               next_state = st_idle;
            end
         endcase
      end
   end

   // Frame state; a stop on the bus clears it
   // R8: clock only read
   // R11: no rate limit
   always_ff @(negedge scl_link or posedge bus_free) begin
      if (bus_free) begin
         state <= st_idle;
         cnt <= '0;
         shreg <= '0;
         sda_oe <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         shreg <= next_shreg;
         sda_oe <= next_oe;
      end
   end

   // Pointer and toggles survive a stop; only reset clears them
   always_ff @(negedge scl_link or posedge link_rst) begin
      if (link_rst) begin
         ptr <= `PTR_RESET;
         hs_tgl <= 1'b0;
         cm_tgl <= 1'b0;
         cm_addr <= '0;
         cm_data <= '0;
      end else begin
         ptr <= next_ptr;
         hs_tgl <= next_hs_tgl;
         cm_tgl <= next_cm_tgl;
         cm_addr <= next_cm_addr;
         cm_data <= next_cm_data;
      end
   end

   // ----------------------------------------
   // System domain
   // ----------------------------------------
   logic scl_m;
   logic scl_s;
   logic scl_p;
   logic sda_m;
   logic sda_s;
   logic sda_p;
   logic [2:0] hs_sync;
   logic [2:0] cm_sync;
   logic start_evt;
   logic stop_evt;
   logic hs_evt;
   logic cm_evt;
   logic next_free;
   logic next_filt;
   logic next_wr;
   byte_t next_wr_addr;
   byte_t next_wr_data;
   regfile_if #(.AW(AW), .DW(DW)) rf ();

   // Edge events from resynchronised pins and toggles
   always_comb begin
      // R20: bus conditions
      start_evt = scl_s & scl_p & sda_p & ~sda_s;
      stop_evt = scl_s & scl_p & ~sda_p & sda_s;
      hs_evt = hs_sync[2] ^ hs_sync[1];
      cm_evt = cm_sync[2] ^ cm_sync[1];
   end

   // Bus free flag, filter select and write strobe
   always_comb begin
      next_free = bus_free;
      if (stop_evt) begin
         next_free = 1'b1;
      end else if (start_evt) begin
         next_free = 1'b0;
      end
      // R12: stop selects slow
      // R13: start leaves it
      next_filt = filt_hs;
      if (hs_evt) begin
         next_filt = 1'b1;
      end else if (stop_evt) begin
         next_filt = 1'b0;
      end
      // Commit data stays still for a whole byte, so it is safe to take
      next_wr = cm_evt;
      next_wr_addr = cm_evt ? cm_addr : wr_addr;
      next_wr_data = cm_evt ? cm_data : wr_data;
   end

   // Registers of the system domain, frozen while ce is low
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         link_rst <= 1'b1;
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_p <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_p <= 1'b1;
         hs_sync <= '0;
         cm_sync <= '0;
         bus_free <= 1'b1;
         filt_hs <= 1'b0;
         wr_pulse <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
         sda_o <= 1'b0;
      end else if (ce) begin
         link_rst <= 1'b0;
         scl_m <= scl_link;
         scl_s <= scl_m;
         scl_p <= scl_s;
         sda_m <= sda_i;
         sda_s <= sda_m;
         sda_p <= sda_s;
         hs_sync <= {hs_sync[1:0], hs_tgl};
         cm_sync <= {cm_sync[1:0], cm_tgl};
         bus_free <= next_free;
         filt_hs <= next_filt;
         wr_pulse <= next_wr;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
         sda_o <= 1'b0;
      end
   end

   // Register store hook-up
   assign rf.ce = ce;
   assign rf.we = wr_pulse;
   assign rf.waddr = wr_addr;
   assign rf.wdata = wr_data;
   assign rf.raddr = rd_addr;
   assign rd_data = rf.rdata;

   reg_store #(.AW(AW), .DW(DW)) u_store (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .bus(rf.store)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // R5: main address
   a_main_addr_ack: assert property (@(negedge scl_link) disable iff (bus_free) // R5
      (state == st_addr && cnt == `LAST_BIT && !start_now && dir_wr
       && rx_byte[7:1] == main_addr(opt_s)) |=> sda_oe)
      else $error("main address not acknowledged");
   // R6: foreign nack
   a_foreign_nack: assert property (@(negedge scl_link) disable iff (bus_free) // R6
      (state == st_addr && cnt == `LAST_BIT && !start_now && !addr_hit) |=> !sda_oe)
      else $error("foreign address acknowledged");
   // R9: general call
   a_gcall_nack: assert property (@(negedge scl_link) disable iff (bus_free) // R9
      (state == st_addr && cnt == `LAST_BIT && !start_now && rx_byte == 8'h00)
      |=> !sda_oe ##1 (state == st_ignore || state == st_addr))
      else $error("general call answered");
   // R7: test gate
   a_test_locked: assert property (@(negedge scl_link) disable iff (bus_free) // R7
      (state == st_addr && cnt == `LAST_BIT && !start_now && !unlock_s
       && rx_byte[7:1] == `ADDR_TEST) |=> !sda_oe)
      else $error("locked test address acknowledged");
   // R3: any pointer
   a_ptr_ack: assert property (@(negedge scl_link) disable iff (bus_free) // R3
      (state == st_ptr && cnt == `LAST_BIT && !start_now) |=> sda_oe ##1 !sda_oe)
      else $error("pointer byte not acknowledged");
   // R1: one ack clock
   a_ack_single: assert property (@(negedge scl_link) disable iff (bus_free) // R1
      sda_oe |=> !sda_oe)
      else $error("acknowledge held past ninth clock");
   // R17: pointer steps
   a_ptr_step: assert property (@(negedge scl_link) disable iff (bus_free) // R17
      (state == st_data && cnt == `ACK_SLOT && !start_now)
      |=> ptr == $past(ptr) + `PTR_STEP && cm_tgl != $past(cm_tgl))
      else $error("pointer did not advance after data byte");
   // R23: quiet ignore
   a_ignore_quiet: assert property (@(negedge scl_link) disable iff (bus_free) // R23
      state == st_ignore |-> !sda_oe)
      else $error("data driven while ignoring");
   // R12: stop clears
   a_stop_filter: assert property (@(posedge clk_sys) disable iff (!resetn) // R12
      (ce && stop_evt && !hs_evt) |=> !filt_hs)
      else $error("stop left fast filters selected");
   // R22: hs entry
   a_hs_enter: assert property (@(posedge clk_sys) disable iff (!resetn) // R22
      (ce && hs_evt) |=> filt_hs)
      else $error("master code did not select fast filters");
   // R15: commit write
   a_commit_write: assert property (@(posedge clk_sys) disable iff (!resetn) // R15
      (ce && cm_evt) |=> wr_pulse && wr_addr == $past(cm_addr))
      else $error("committed byte not written");

   c_write_seq: cover property (@(posedge clk_sys) disable iff (!resetn) wr_pulse);
   c_hs_entry: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(filt_hs));
   c_ignore: cover property (@(negedge scl_link) disable iff (bus_free)
      state == st_ignore);
   c_restart: cover property (@(negedge scl_link) disable iff (bus_free)
      start_now && state == st_data);
endmodule : i2c_wr_target

// *** design/reg_store.sv ***
// Register store written by the serial target, one registered read port
`timescale 1ns/1ps
module reg_store #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input wire logic clk_sys,
   input wire logic resetn,
   regfile_if.store bus
);
   logic [DW-1:0] cells [2**AW];
   logic [DW-1:0] rdata;
   logic [DW-1:0] next_rdata;

   // Read data comes from a register, one cycle behind the address
   always_comb begin
      next_rdata = cells[bus.raddr];
   end

   // ----------------------------------------
   // Storage and read register
   // ----------------------------------------
   // Cells carry no reset; software must write before relying on them
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rdata <= '0;
      end else if (bus.ce) begin
         rdata <= next_rdata;
         if (bus.we) begin
            cells[bus.waddr] <= bus.wdata;
         end
      end
   end

   assign bus.rdata = rdata;
endmodule : reg_store

// *** design/regfile_if.sv ***
// Carrier between the protocol engine and the register store
`timescale 1ns/1ps
interface regfile_if #(
   parameter int AW = 8,
   parameter int DW = 8
);
   logic ce;
   logic we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;
   modport ctrl (output ce, output we, output waddr, output wdata, output raddr, input rdata);
   modport store (input ce, input we, input waddr, input wdata, input raddr, output rdata);
endinterface : regfile_if
